// [pfa_ecu_model.sv]
// receiver model: sync pulses out, manchester frames in
`timescale 1ns/1ns
`default_nettype none
module pfa_ecu_model #(
    parameter int unsigned SYNC_PER = 600
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic line_hi, // sink
    input wire logic sync_on, // pulses wanted
    output logic sync_pulse, // sync out
    output logic frm_vld, // frame done
    output logic [31:0] frm_bits, // bit 0 first
    output logic [5:0] frm_n, // bit count
    output logic [15:0] frm_lat // sync to first edge
);
    logic act, prev, first;
    logic [15:0] t, since;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {act, prev, first, sync_pulse, frm_vld, frm_n, frm_bits, frm_lat, t, since} <= '0;
        end else begin
            prev <= line_hi;
            frm_vld <= 1'h0;
            since <= (since == 16'(SYNC_PER - 1)) ? 16'h0000 : since + 16'h0001;
            sync_pulse <= sync_on && since == 16'h0000;
            if (!act && line_hi && !prev) begin
                {act, t, first, frm_n, frm_bits, frm_lat} <= {1'h1, 16'h0001, 1'h0, 6'h00, 32'h0, since};
            end else if (act) begin
                t <= t + 16'h0001;
                if (t[2:0] == 3'h6) first <= line_hi;
                // a missing mid-bit edge ends the frame
                if (t[2:0] == 3'h2 && line_hi != first) begin
                    frm_bits[frm_n[4:0]] <= !line_hi;
                    frm_n <= frm_n + 6'h01;
                end else if (t[2:0] == 3'h2) begin
                    act <= 1'h0;
                    frm_vld <= 1'h1;
                end
            end
        end
    end
endmodule : pfa_ecu_model
`default_nettype wire

// [pfa_manch_tx.sv]
// manchester serialiser: shifts a frame word lsb first, one bit per bit time
`timescale 1ns/1ns
`default_nettype none
module pfa_manch_tx #(
    parameter int unsigned BIT_CYC = 2000,
    parameter int unsigned MAXB = 29
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic start, // load and send frame
    input wire logic [MAXB-1:0] bits, // frame bits, bit 0 first
    input wire logic [4:0] nbits, // number of bits
    output logic busy, // frame in progress
    output logic line_hi // current sink high
);
    localparam int unsigned HALF = BIT_CYC / 2;
    logic [MAXB-1:0] sh_r, sh_nxt;
    logic [4:0] left_r, left_nxt;
    logic [15:0] cyc_r, cyc_nxt;
    logic busy_r, busy_nxt;
    logic out_r, out_nxt;

    always_comb begin
        sh_nxt = sh_r;
        left_nxt = left_r;
        cyc_nxt = cyc_r;
        busy_nxt = busy_r;
        out_nxt = out_r;
        if (!busy_r) begin
            out_nxt = 1'b0;
            if (start) begin
                sh_nxt = bits;
                left_nxt = nbits;
                cyc_nxt = 16'h0000;
                busy_nxt = 1'b1;
                out_nxt = bits[0];
            end
        end else begin
            cyc_nxt = cyc_r + 16'h0001;
            if (cyc_r == 16'(HALF - 1)) begin
                out_nxt = ~sh_r[0];
            end else if (cyc_r == 16'(BIT_CYC - 1)) begin
                cyc_nxt = 16'h0000;
                sh_nxt = sh_r >> 1;
                left_nxt = left_r - 5'h01;
                if (left_r == 5'h01) begin
                    busy_nxt = 1'b0;
                    out_nxt = 1'b0;
                end else begin
                    out_nxt = sh_r[1];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= '0;
            left_r <= 5'h00;
            cyc_r <= 16'h0000;
            busy_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            left_r <= left_nxt;
            cyc_r <= cyc_nxt;
            busy_r <= busy_nxt;
            out_r <= out_nxt;
        end
    end

    assign busy = busy_r;
    assign line_hi = out_r;
endmodule : pfa_manch_tx
`default_nettype wire

// [pfa_monitor.sv]
// port checks of the frame assembler
`timescale 1ns/1ns
`default_nettype none
module pfa_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic [11:0] paddr, // address
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic uv_reset, // undervoltage
    input wire logic bist_done, // self-test
    input wire logic line_hi, // sink
    input wire logic app_run // app
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // line and init
    // ------------------------------------------------------------
    // low 5 and 9 cycles back: line was idle
    a_start_bits: assert property (
        $rose(line_hi) && !$past(line_hi, 5) && !$past(line_hi, 9) |->
        line_hi[*4] ##1 (!line_hi)[*4] ##1 line_hi[*4]) else $error("bad start bits");
    a_half_bit: assert property ($rose(line_hi) |-> line_hi[*4]) else $error("short half bit");
    a_line_quiet: assert property (!bist_done |-> !line_hi) else $error("line busy in phase one");
    a_app_quiet: assert property (!bist_done |-> !app_run) else $error("app before self-test");
    a_uv_restart: assert property ($rose(uv_reset) |-> ##[1:5] !app_run) else $error("no restart");
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_map_error: assert property (pready |-> pslverr == (paddr > 12'h01C)) else $error("bad error flag");
endmodule : pfa_monitor
`default_nettype wire

// [pfa_ph1_timer.sv]
// phase one timer: waits for self-test done and optionally a long delay
`timescale 1ns/1ns
`default_nettype none
module pfa_ph1_timer #(
    parameter int unsigned DELAY_CYC = 25000000
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic restart, // restart phase one
    input wire logic bist_done, // self-test finished
    input wire logic long_sel, // 1: wait the long delay
    output logic done // phase one over
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (restart) begin
            cnt_nxt = 32'h0000_0000;
            done_nxt = 1'b0;
        end else if (!done_r && bist_done) begin
            if (!long_sel || cnt_r >= 32'(DELAY_CYC - 1)) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0000_0000;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : pfa_ph1_timer
`default_nettype wire

// [pfa_pkg.sv]
// register map, fields and timing constants of the frame assembler
package pfa_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_FRAME = 12'h004;
    localparam logic [11:0] REG_SLOT0 = 12'h008;
    localparam logic [11:0] REG_SLOT1 = 12'h00C;
    localparam logic [11:0] REG_SLOT2 = 12'h010;
    localparam logic [11:0] REG_DATA = 12'h014;
    localparam logic [11:0] REG_STATUS = 12'h018;
    localparam logic [11:0] REG_INIT = 12'h01C;
    // ------------------------------------------------------------
    // ctrl fields
    // ------------------------------------------------------------
    localparam int CTRL_SYNC_MODE = 0;
    localparam int CTRL_FC_EN = 1;
    localparam int CTRL_FC_SRC = 2;
    localparam int CTRL_STAT_EN = 3;
    localparam int CTRL_CRC_SEL = 4;
    localparam int CTRL_QUAD_EN = 5;
    localparam int CTRL_PH1_LEN = 6;
    localparam int CTRL_INIT_SEQ_LO = 7;
    localparam int CTRL_ERR = 9;
    localparam int CTRL_RESTART = 10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // frame fields: data size lo, payload size lo, per source
    // ------------------------------------------------------------
    localparam int FRM_POS_DSZ_LO = 0;
    localparam int FRM_POS_PSZ_LO = 5;
    localparam int FRM_SPD_DSZ_LO = 10;
    localparam int FRM_SPD_PSZ_LO = 15;
    localparam logic [31:0] FRAME_RST = 32'h0000_0000;
    localparam logic [4:0] PAY_MIN = 5'h09;
    localparam logic [4:0] PAY_POS_MAX = 5'h18;
    localparam logic [4:0] PAY_SPD_MAX = 5'h10;
    // slot register: [15:0] start delay in bit times, [17:16] source, [18] enable
    localparam int SLOT_SRC_LO = 16;
    localparam int SLOT_EN = 18;
    // ------------------------------------------------------------
    // enumerations and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PFA_SRC_POS = 2'b00,
        PFA_SRC_POS_QUAD = 2'b01,
        PFA_SRC_SPEED = 2'b10
    } pfa_src_e;
    localparam logic [2:0] FC_CODE_POS = 3'h1;
    localparam logic [2:0] FC_CODE_POSQ = 3'h2;
    localparam logic [2:0] FC_CODE_SPD = 3'h4;
    localparam int CLK_MHZ = 250;
    localparam int BIT_NS = 8000;
    localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
    localparam int PH1_MS = 100;
    localparam int PH1_CYC = PH1_MS * CLK_MHZ * 1000;
    localparam int MAX_BITS = 2 + 24 + 3;
endpackage : pfa_pkg

// [pfa_top.sv]
// sensor frame assembler with init sequencing and apb registers
// Overview of operation
// - every frame opens with two start bits, both zero
// - optional three control bits carry rolling counter or source code
// - optional status bit carries internal error flag
// - data bits go out least significant bit first, count configurable
// - payload size configurable from nine to twenty-four bits
// - each slot picks position, position plus quadrant, or speed
// - payload size per source; position 9-24, speed 9-16 bits
// - quadrant bits appended to position and sent in same slot
// - unused payload positions are filled with zeros
// - power-on or undervoltage reset restarts initialization
// - init sequence setting ends init after phase one, two or three
// - no new frames scheduled during init phase one; a restart does not abort a frame already under way
// - phase one ends after self-test, or about 100 ms after self-test when the long delay is selected
// - manchester bits, rising mid edge is zero, falling is one
// - sync mode starts each slot frame once the idle bit times since the sync pulse reach its programmed delay
// - status bit forced to zero during init phase two
`timescale 1ns/1ns
`default_nettype none
module pfa_top #(
    parameter int unsigned PH1_DELAY = pfa_pkg::PH1_CYC,
    parameter int unsigned BIT_CYC = pfa_pkg::BIT_CYC
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic uv_reset, // undervoltage reset pin
    input wire logic sync_pulse, // sync pulse detector pin
    input wire logic bist_done, // self-test finished pin
    input wire logic [23:0] pos_data, // position value
    input wire logic [1:0] quad_data, // quadrant bits
    input wire logic [15:0] speed_data, // angular speed value
    output logic line_hi, // current sink high
    output logic app_run // normal output running
);
    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PFA_PH1 = 2'b00,
        PFA_PH2 = 2'b01,
        PFA_PH3 = 2'b10,
        PFA_APP = 2'b11
    } pfa_init_e;

    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] frame_r, frame_nxt;
    logic [31:0] slot_r [3], slot_nxt [3];
    logic [15:0] initw_r, initw_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    pfa_init_e st_r, st_nxt;
    logic [1:0] slot_idx_r, slot_idx_nxt;
    logic [15:0] dly_r, dly_nxt;
    logic [15:0] bt_r, bt_nxt;
    logic waiting_r, waiting_nxt;
    logic [2:0] roll_r, roll_nxt;
    logic [3:0] ph_cnt_r, ph_cnt_nxt;
    logic go_r, go_nxt;
    logic [pfa_pkg::MAX_BITS-1:0] word_r, word_nxt;
    logic [4:0] nb_r, nb_nxt;
    logic app_r;
    logic [2:0] uv_s_r, sy_s_r, bd_s_r;
    logic ph1_done, tx_busy, tx_line, restart;

    // check field: parity over payload, or 3-bit crc (poly x^3+x+1, seed 010)
    function automatic logic [2:0] pfa_check(input logic [23:0] pay, input logic [4:0] n, input logic crc);
        logic [2:0] c;
        logic fb;
        c = 3'h2;
        fb = 1'b0;
        for (int i = 0; i < 24; i++) begin
            if (5'(i) < n) begin
                fb = c[2] ^ pay[i];
                c = {c[1], c[0] ^ fb, fb};
            end
        end
        pfa_check = crc ? c : {2'b00, ^pay};
    endfunction : pfa_check

    function automatic logic [4:0] pfa_clip(input logic [4:0] v, input logic [4:0] hi);
        pfa_clip = (v < pfa_pkg::PAY_MIN) ? pfa_pkg::PAY_MIN : ((v > hi) ? hi : v);
    endfunction : pfa_clip

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_s_r <= 3'h0;
            sy_s_r <= 3'h0;
            bd_s_r <= 3'h0;
        end else begin
            uv_s_r <= {uv_s_r[1:0], uv_reset};
            sy_s_r <= {sy_s_r[1:0], sync_pulse};
            bd_s_r <= {bd_s_r[1:0], bist_done};
        end
    end

    assign restart = (uv_s_r[1] && !uv_s_r[2]) || ctrl_r[pfa_pkg::CTRL_RESTART];

    pfa_ph1_timer #(.DELAY_CYC(PH1_DELAY)) u_ph1 (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .bist_done(bd_s_r[1]),
        .long_sel(ctrl_r[pfa_pkg::CTRL_PH1_LEN]),
        .done(ph1_done)
    );

    pfa_manch_tx #(.BIT_CYC(BIT_CYC), .MAXB(pfa_pkg::MAX_BITS)) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .start(go_r),
        .bits(word_r),
        .nbits(nb_r),
        .busy(tx_busy),
        .line_hi(tx_line)
    );

    // ------------------------------------------------------------
    // apb slave, one wait-free access phase
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt[pfa_pkg::CTRL_RESTART] = 1'b0;
        frame_nxt = frame_r;
        initw_nxt = initw_r;
        slot_nxt = slot_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = psel && !penable;
        if (psel && !penable) begin
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                pfa_pkg::REG_CTRL: prdata_nxt = ctrl_r;
                pfa_pkg::REG_FRAME: prdata_nxt = frame_r;
                pfa_pkg::REG_SLOT0: prdata_nxt = slot_r[0];
                pfa_pkg::REG_SLOT1: prdata_nxt = slot_r[1];
                pfa_pkg::REG_SLOT2: prdata_nxt = slot_r[2];
                pfa_pkg::REG_DATA: prdata_nxt = {pos_data[15:0], speed_data};
                pfa_pkg::REG_STATUS: prdata_nxt = {25'h0, tx_busy, ph_cnt_r[1:0], roll_r, app_r};
                pfa_pkg::REG_INIT: prdata_nxt = {16'h0000, initw_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (psel && penable && pready_r && pwrite && !pslverr_r) begin
            case (paddr)
                pfa_pkg::REG_CTRL: ctrl_nxt = pwdata;
                pfa_pkg::REG_FRAME: frame_nxt = pwdata;
                pfa_pkg::REG_SLOT0: slot_nxt[0] = pwdata;
                pfa_pkg::REG_SLOT1: slot_nxt[1] = pwdata;
                pfa_pkg::REG_SLOT2: slot_nxt[2] = pwdata;
                pfa_pkg::REG_INIT: initw_nxt = pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // init sequencer and slot scheduler
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] src;
        logic [4:0] dsz, psz, n, ssz;
        logic [23:0] dat, pay;
        logic [2:0] fc;
        logic e0;
        src = 2'b00;
        dsz = 5'h00;
        psz = 5'h00;
        n = 5'h00;
        ssz = 5'h00;
        dat = 24'h0;
        pay = 24'h0;
        fc = 3'h0;
        e0 = 1'b0;
        st_nxt = st_r;
        slot_idx_nxt = slot_idx_r;
        dly_nxt = dly_r;
        bt_nxt = bt_r;
        waiting_nxt = waiting_r;
        roll_nxt = roll_r;
        ph_cnt_nxt = ph_cnt_r;
        go_nxt = 1'b0;
        word_nxt = word_r;
        nb_nxt = nb_r;
        case (st_r)
            PFA_PH1: begin
                waiting_nxt = 1'b0;
                if (ph1_done) begin
                    case (ctrl_r[pfa_pkg::CTRL_INIT_SEQ_LO +: 2])
                        2'b01, 2'b10: st_nxt = PFA_PH2;
                        default: st_nxt = PFA_APP;
                    endcase
                end
            end
            default: begin
                if (!waiting_r && !tx_busy && !go_r) begin
                    if (!ctrl_r[pfa_pkg::CTRL_SYNC_MODE] || (sy_s_r[1] && !sy_s_r[2])) begin
                        waiting_nxt = 1'b1;
                        slot_idx_nxt = 2'b00;
                        dly_nxt = 16'h0000;
                        bt_nxt = 16'h0000;
                    end
                end else if (waiting_r && !tx_busy && !go_r) begin
                    if (slot_idx_r == 2'b11) begin
                        waiting_nxt = 1'b0;
                        if (st_r != PFA_APP) begin
                            ph_cnt_nxt = ph_cnt_r + 4'h1;
                            if (ph_cnt_r == 4'hF) begin
                                st_nxt = (st_r == PFA_PH2 && ctrl_r[pfa_pkg::CTRL_INIT_SEQ_LO +: 2] == 2'b10)
                                    ? PFA_PH3 : PFA_APP;
                            end
                        end
                    end else if (!slot_r[slot_idx_r][pfa_pkg::SLOT_EN]) begin
                        slot_idx_nxt = slot_idx_r + 2'b01;
                    end else if (dly_r < slot_r[slot_idx_r][15:0]) begin
                        bt_nxt = bt_r + 16'h0001;
                        if (bt_r == 16'(BIT_CYC - 1)) begin
                            bt_nxt = 16'h0000;
                            dly_nxt = dly_r + 16'h0001;
                        end
                    end else begin
                        src = slot_r[slot_idx_r][pfa_pkg::SLOT_SRC_LO +: 2];
                        if (src == pfa_pkg::PFA_SRC_SPEED) begin
                            dsz = pfa_clip(frame_r[pfa_pkg::FRM_SPD_DSZ_LO +: 5], pfa_pkg::PAY_SPD_MAX);
                            psz = pfa_clip(frame_r[pfa_pkg::FRM_SPD_PSZ_LO +: 5], pfa_pkg::PAY_SPD_MAX);
                            dat = {8'h00, speed_data};
                            fc = pfa_pkg::FC_CODE_SPD;
                        end else begin
                            dsz = pfa_clip(frame_r[pfa_pkg::FRM_POS_DSZ_LO +: 5], pfa_pkg::PAY_POS_MAX);
                            psz = pfa_clip(frame_r[pfa_pkg::FRM_POS_PSZ_LO +: 5], pfa_pkg::PAY_POS_MAX);
                            dat = pos_data;
                            fc = pfa_pkg::FC_CODE_POS;
                            if (src == pfa_pkg::PFA_SRC_POS_QUAD && ctrl_r[pfa_pkg::CTRL_QUAD_EN]) begin
                                dat = (pos_data & ((24'h000001 << dsz) - 24'h000001)) | (24'(quad_data) << dsz);
                                dsz = dsz + 5'h02;
                                fc = pfa_pkg::FC_CODE_POSQ;
                            end
                        end
                        if (!ctrl_r[pfa_pkg::CTRL_FC_SRC]) fc = roll_r;
                        e0 = ctrl_r[pfa_pkg::CTRL_ERR] && (st_r != PFA_PH2);
                        n = 5'h00;
                        if (ctrl_r[pfa_pkg::CTRL_FC_EN]) begin
                            pay[2:0] = fc;
                            n = 5'h03;
                        end
                        if (ctrl_r[pfa_pkg::CTRL_STAT_EN]) begin
                            pay[n] = e0;
                            n = n + 5'h01;
                        end
                        // bits beyond the data and below psz stay zero
                        pay = pay | ((dat & ((24'h000001 << dsz) - 24'h000001)) << n);
                        pay = pay & ((24'h000001 << psz) - 24'h000001);
                        ssz = ctrl_r[pfa_pkg::CTRL_CRC_SEL] ? 5'h03 : 5'h01;
                        word_nxt = {3'h0, pay, 2'b00}
                            | (pfa_pkg::MAX_BITS'(pfa_check(pay, psz, ctrl_r[pfa_pkg::CTRL_CRC_SEL]))
                               << (psz + 5'h02));
                        nb_nxt = psz + 5'h02 + ssz;
                        go_nxt = 1'b1;
                        roll_nxt = roll_r + 3'h1;
                        slot_idx_nxt = slot_idx_r + 2'b01;
                    end
                end
            end
        endcase
        if (restart) begin
            st_nxt = PFA_PH1;
            waiting_nxt = 1'b0;
            ph_cnt_nxt = 4'h0;
            go_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= pfa_pkg::CTRL_RST;
            frame_r <= pfa_pkg::FRAME_RST;
            slot_r <= '{3{32'h0000_0000}};
            initw_r <= 16'h0000;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            st_r <= PFA_PH1;
            slot_idx_r <= 2'b00;
            dly_r <= 16'h0000;
            bt_r <= 16'h0000;
            waiting_r <= 1'b0;
            roll_r <= 3'h0;
            ph_cnt_r <= 4'h0;
            go_r <= 1'b0;
            word_r <= '0;
            nb_r <= 5'h00;
            app_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            frame_r <= frame_nxt;
            slot_r <= slot_nxt;
            initw_r <= initw_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            st_r <= st_nxt;
            slot_idx_r <= slot_idx_nxt;
            dly_r <= dly_nxt;
            bt_r <= bt_nxt;
            waiting_r <= waiting_nxt;
            roll_r <= roll_nxt;
            ph_cnt_r <= ph_cnt_nxt;
            go_r <= go_nxt;
            word_r <= word_nxt;
            nb_r <= nb_nxt;
            app_r <= (st_nxt == PFA_APP);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign line_hi = tx_line;
    assign app_run = app_r;
endmodule : pfa_top
`default_nettype wire

// [pfa_top_tb.sv]
// self-checking bench of the frame assembler
`timescale 1ns/1ns
`default_nettype none
module pfa_top_tb;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, uv_reset = 1'h0;
    logic bist_done = 1'h0, sync_on = 1'h0, pready, pslverr, line_hi, app_run, sync_pulse, frm_vld, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, frm_bits, rd;
    logic [23:0] pos_data = 24'h0;
    logic [15:0] speed_data = 16'h0, frm_lat;
    logic [1:0] quad_data = 2'h0;
    logic [5:0] frm_n;
    int error_cnt = 0, comparisons = 0, pd = 9, pp = 9, sd = 9, sp = 16, dly;
    pfa_top #(.PH1_DELAY(50), .BIT_CYC(8)) i_dut (.*);
    pfa_ecu_model i_ecu (.*);
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(input logic frm);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((frm ? frm_vld : pready) !== 1'h1 && n < 4000);
        if (n >= 4000) chk(32'h0, 32'h1);
        if (n >= 4000) summarize();
    endtask : wait_hi
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        wait_hi(1'h0);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask : apb
    function automatic int plen(input logic [1:0] s);
        return 2 + (s == 2'h2 ? sp : pp);
    endfunction : plen
    function automatic logic [31:0] exp_bits(input logic [1:0] s, input logic [31:0] c, input logic e0);
        logic [31:0] v;
        logic [25:0] d;
        int i, n;
        v = 32'h0;
        i = 2;
        n = s == 2'h2 ? sd : pd;
        d = s == 2'h2 ? 26'(speed_data) : 26'(pos_data) & ~(26'h3FFFFFF << n);
        if (c[1]) v[i +: 3] = s == 2'h0 ? pfa_pkg::FC_CODE_POS : s == 2'h1 ? pfa_pkg::FC_CODE_POSQ : pfa_pkg::FC_CODE_SPD;
        if (c[1]) i += 3;
        if (c[3]) v[i] = e0;
        if (c[3]) i++;
        if (s == 2'h1) d = d | (26'(quad_data) << n);
        if (s == 2'h1) n += 2;
        for (int k = 0; k < n; k++) v[i + k] = d[k];
        return v & ((32'h1 << plen(s)) - 32'h1);
    endfunction : exp_bits
    // first frame may predate the setup
    task automatic see(input logic [1:0] s, input logic [31:0] c, input logic e0);
        wait_hi(1'h1);
        wait_hi(1'h1);
        chk(frm_bits & ((32'h1 << plen(s)) - 32'h1), exp_bits(s, c, e0));
        chk(32'(frm_n), 32'(plen(s) + (c[4] ? 3 : 1)));
    endtask : see
    task automatic run(input logic [1:0] s, input logic [31:0] c);
        {pos_data, quad_data, speed_data} <= {24'($urandom), 2'($urandom), 16'($urandom)};
        apb(1'h1, pfa_pkg::REG_CTRL, c);
        apb(1'h1, pfa_pkg::REG_SLOT0, {13'h0, 1'h1, s, 16'h0004});
        see(s, c, c[9]);
    endtask : run
    initial begin
        void'($urandom(22));
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h1, pfa_pkg::REG_FRAME, {12'h000, 5'(sp), 5'(sd), 5'(pp), 5'(pd)});
        repeat (100) @(posedge pclk);
        chk(32'(app_run), 32'h0);
        bist_done <= 1'h1;
        run(2'h0, 32'h0);
        chk(32'(app_run), 32'h1);
        pp = 24;
        pd = $urandom_range(18, 12);
        sd = $urandom_range(12, 9);
        apb(1'h1, pfa_pkg::REG_FRAME, {12'h000, 5'(sp), 5'(sd), 5'(pp), 5'(pd)});
        for (int s = 0; s < 6; s++) run(2'(s % 3), {22'h0, 1'(s > 2), 3'h0, 1'h1, 1'(s % 2), 3'h7, 1'h0});
        dly = $urandom_range(5, 2);
        apb(1'h1, pfa_pkg::REG_SLOT0, {13'h0, 1'h1, 2'h0, 16'(dly)});
        apb(1'h1, pfa_pkg::REG_CTRL, 32'h0000_000F);
        sync_on <= 1'h1;
        see(2'h0, 32'h0000_000F, 1'h0);
        chk(32'(frm_lat >= 16'(dly * 8 + 4) && frm_lat <= 16'(dly * 8 + 16)), 32'h1);
        sync_on <= 1'h0;
        apb(1'h1, pfa_pkg::REG_CTRL, 32'h0000_028E);
        uv_reset <= 1'h1;
        repeat (8) @(posedge pclk);
        chk(32'(app_run), 32'h0);
        uv_reset <= 1'h0;
        see(2'h0, 32'h0000_028E, 1'h0);
        repeat (18) wait_hi(1'h1);
        chk(32'(app_run), 32'h1);
        see(2'h0, 32'h0000_028E, 1'h1);
        apb(1'h1, pfa_pkg::REG_CTRL, 32'h0000_0440);
        repeat (30) @(posedge pclk);
        chk(32'(app_run), 32'h0);
        repeat (60) @(posedge pclk);
        chk(32'(app_run), 32'h1);
        apb(1'h0, pfa_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0040);
        apb(1'h0, 12'h020, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        summarize();
    end
endmodule : pfa_top_tb
bind pfa_top pfa_monitor i_mon (.*);
`default_nettype wire
